// ---- hdl/fsrf_pkg.sv ----
// constants, encodings and register layout of the flash power/program/read config block
// assumes apb on pclk, spi link clocked by the host, mode 0 sampling on rising edge
package fsrf_pkg;
  // link instructions
  localparam logic [7:0] CMD_POWER_DOWN = 8'hB9;
  localparam logic [7:0] CMD_ULTRA_SLEEP = 8'h79;
  localparam logic [7:0] CMD_WAKE = 8'hAB;
  localparam logic [7:0] CMD_SET_WRAP = 8'h77;
  localparam logic [7:0] CMD_QREAD_A = 8'hE7;
  localparam logic [7:0] CMD_QREAD_B = 8'hEB;
  localparam logic [7:0] CMD_SEQ_PROG = 8'hAD;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  // register byte offsets
  localparam logic [11:0] OFS_PPRC = 12'h000;
  localparam logic [11:0] OFS_CFG = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  // field positions
  localparam int BIT_PDS = 7;
  localparam int BIT_SEQ = 6;
  localparam int BIT_XIP = 3;
  localparam int BIT_QE = 0;
  localparam int WRAP_SRC_LSB = 4;
  // reset values
  localparam logic [2:0] WRAP_RESET = 3'b001;
  localparam logic [23:0] ADDR_RESET = 24'h00_0000;
  // cycle counts on the link
  localparam logic [4:0] CMD_LAST = 5'd7;
  localparam logic [4:0] ADDR_LAST_QUAD = 5'd5;
  localparam logic [4:0] ADDR_LAST_SINGLE = 5'd23;
  localparam logic [4:0] DUMMY_LAST = 5'd1;
  localparam logic [4:0] BYTE_LAST = 5'd7;
  typedef enum logic [2:0] {
    LS_CMD = 3'b000,
    LS_ADDR = 3'b001,
    LS_DUMMY = 3'b011,
    LS_DATA = 3'b010,
    LS_WRAP = 3'b110,
    LS_IGNORE = 3'b111
  } fsrf_lstate_t;
  // link state kept across frames
  typedef struct packed {
    logic sleep;
    logic ultra;
    logic seq;
    logic [23:0] seq_addr;
    logic cont;
    logic [2:0] wrap;
    logic wrap_tgl;
    logic buf_valid;
    logic pds_s1;
    logic pds_s2;
    logic xip_s1;
    logic xip_s2;
    logic qe_s1;
    logic qe_s2;
  } fsrf_link_t;
  // link state that ends with each frame
  typedef struct packed {
    fsrf_lstate_t state;
    logic [4:0] cnt;
    logic [7:0] shreg;
    logic [23:0] addr;
    logic quad;
    logic rd;
    logic [3:0] io_out;
    logic [3:0] io_oe;
  } fsrf_frame_t;
  // bus side state
  typedef struct packed {
    logic pds;
    logic continuous_read_select;
    logic qe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sleep_s1;
    logic sleep_s2;
    logic ultra_s1;
    logic ultra_s2;
    logic seq_s1;
    logic seq_s2;
    logic cont_s1;
    logic cont_s2;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic buf_s1;
    logic buf_s2;
    logic hold_en;
    logic [2:0] wrap;
  } fsrf_bus_t;
endpackage

// ---- hdl/fsrf_top.sv ----
// power/program/read config register bank with its spi instruction front end
// assumes an apb master on pclk and an spi host that drives spi_sck only inside frames
`timescale 1ns/1ps
// Notes on behaviour
// - power-down with depth select 0 enters ultra-deep sleep and drops the page buffer.
// - power-down with depth select 0 acts exactly like the ultra-deep sleep instruction.
// - power-down with depth select 1 enters deep sleep and keeps the page buffer.
// - either sleep is left only by the wake instruction sent by the host.
// - toggling chip select alone never wakes the device.
// - the sequential flag resets to 0 and cannot be written by software.
// - in sequential mode only the first transfer carries an address, later ones continue on.
// - continuous-read select resets to 0 so every quad read needs its instruction.
// - with continuous-read set only the first quad read carries the instruction, 1-4-4.
// - the instruction comes on io0 alone, quad read address and data use all four lines.
// - after the first continuous read, accesses are taken with address and data only.
// - instruction-less access needs both continuous-read select and quad enable at 1.
// - the wrap field mirrors bits 6:4 of the set-wrap byte and resets to 001.
// - with quad enable set the hold pin is a data line and hold is off.
module fsrf_top
  import fsrf_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  output logic sleep_active,
  output logic ultra_deep_active,
  output logic page_buf_valid,
  output logic hold_function_en
);

  fsrf_link_t lk_q, lk_d;
  fsrf_frame_t fr_q, fr_d;
  fsrf_bus_t bs_q, bs_d;
  logic frame_rst_n;
  logic held;
  logic cont_ok;
  logic cmd_done;
  logic [7:0] cmd_next;
  logic [7:0] byte_next;

  // frame logic restarts whenever chip select is high; sck may be stopped then
  assign frame_rst_n = presetn & ~spi_cs_n;
  // hold only acts while io3 is not a data line
  assign held = ~lk_q.qe_s2 & ~io_in[3];
  assign cont_ok = lk_q.cont & lk_q.xip_s2 & lk_q.qe_s2;
  assign cmd_next = {fr_q.shreg[6:0], io_in[0]};
  assign byte_next = cmd_next;
  assign cmd_done = (fr_q.state == LS_CMD) && (fr_q.cnt == CMD_LAST) && !held;

  always_comb begin
    lk_d = lk_q;
    fr_d = fr_q;
    lk_d.pds_s1 = bs_q.pds;
    lk_d.pds_s2 = lk_q.pds_s1;
    lk_d.xip_s1 = bs_q.continuous_read_select;
    lk_d.xip_s2 = lk_q.xip_s1;
    lk_d.qe_s1 = bs_q.qe;
    lk_d.qe_s2 = lk_q.qe_s1;
    // armed continuous mode dies as soon as either enable drops
    lk_d.cont = lk_q.cont & lk_q.xip_s2 & lk_q.qe_s2;
    if (!held) begin
      case (fr_q.state)
        LS_CMD: begin
          if (fr_q.cnt == 5'd0 && cont_ok && !lk_q.sleep) begin
            // first clock already carries an address nibble
            fr_d.addr = {fr_q.addr[19:0], io_in};
            fr_d.quad = 1'b1;
            fr_d.rd = 1'b1;
            fr_d.cnt = 5'd1;
            fr_d.state = LS_ADDR;
          end else if (fr_q.cnt != CMD_LAST) begin
            fr_d.shreg = cmd_next;
            fr_d.cnt = fr_q.cnt + 5'd1;
          end else begin
            fr_d.shreg = cmd_next;
            fr_d.cnt = 5'd0;
            fr_d.state = LS_IGNORE;
            if (lk_q.sleep) begin
              if (cmd_next == CMD_WAKE) begin
                lk_d.sleep = 1'b0;
                lk_d.ultra = 1'b0;
              end
            end else begin
              case (cmd_next)
                CMD_POWER_DOWN: begin
                  lk_d.sleep = 1'b1;
                  lk_d.cont = 1'b0;
                  lk_d.ultra = ~lk_q.pds_s2;
                  if (!lk_q.pds_s2) begin
                    lk_d.buf_valid = 1'b0;
                  end
                end
                CMD_ULTRA_SLEEP: begin
                  lk_d.sleep = 1'b1;
                  lk_d.cont = 1'b0;
                  lk_d.ultra = 1'b1;
                  lk_d.buf_valid = 1'b0;
                end
                CMD_SET_WRAP: begin
                  fr_d.state = LS_WRAP;
                end
                CMD_QREAD_A, CMD_QREAD_B: begin
                  // quad read without quad enable is refused
                  if (lk_q.qe_s2) begin
                    fr_d.state = LS_ADDR;
                    fr_d.quad = 1'b1;
                    fr_d.rd = 1'b1;
                    lk_d.cont = lk_q.xip_s2;
                  end
                end
                CMD_SEQ_PROG: begin
                  fr_d.rd = 1'b0;
                  fr_d.quad = 1'b0;
                  if (lk_q.seq) begin
                    fr_d.addr = lk_q.seq_addr;
                    fr_d.state = LS_DATA;
                  end else begin
                    fr_d.state = LS_ADDR;
                    lk_d.seq = 1'b1;
                  end
                end
                CMD_WRITE_DISABLE: begin
                  lk_d.seq = 1'b0;
                end
                default: begin
                  fr_d.state = LS_IGNORE;
                end
              endcase
            end
          end
        end
        LS_ADDR: begin
          if (fr_q.quad) begin
            fr_d.addr = {fr_q.addr[19:0], io_in};
          end else begin
            fr_d.addr = {fr_q.addr[22:0], io_in[0]};
          end
          fr_d.cnt = fr_q.cnt + 5'd1;
          if (fr_q.cnt == (fr_q.quad ? ADDR_LAST_QUAD : ADDR_LAST_SINGLE)) begin
            fr_d.cnt = 5'd0;
            fr_d.state = fr_q.rd ? LS_DUMMY : LS_DATA;
          end
        end
        LS_DUMMY: begin
          fr_d.cnt = fr_q.cnt + 5'd1;
          if (fr_q.cnt == DUMMY_LAST) begin
            fr_d.cnt = 5'd0;
            fr_d.state = LS_DATA;
            fr_d.io_oe = 4'hF;
            fr_d.io_out = fr_q.addr[3:0];
          end
        end
        LS_DATA: begin
          if (fr_q.rd) begin
            // no array here: read data is an address-seeded nibble count
            fr_d.io_out = fr_q.io_out + 4'h1;
          end else begin
            fr_d.shreg = byte_next;
            fr_d.cnt = fr_q.cnt + 5'd1;
            if (fr_q.cnt == BYTE_LAST) begin
              fr_d.cnt = 5'd0;
              fr_d.addr = fr_q.addr + 24'h00_0001;
              lk_d.seq_addr = fr_q.addr + 24'h00_0001;
              lk_d.buf_valid = 1'b1;
            end
          end
        end
        LS_WRAP: begin
          fr_d.shreg = byte_next;
          fr_d.cnt = fr_q.cnt + 5'd1;
          if (fr_q.cnt == BYTE_LAST) begin
            fr_d.state = LS_IGNORE;
            lk_d.wrap = byte_next[WRAP_SRC_LSB+2:WRAP_SRC_LSB];
            lk_d.wrap_tgl = ~lk_q.wrap_tgl;
          end
        end
        LS_IGNORE: begin
          fr_d.state = LS_IGNORE;
        end
        default: begin
          fr_d.state = LS_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge spi_sck or negedge presetn) begin
    if (!presetn) begin
      lk_q <= '{sleep: 1'b0, ultra: 1'b0, seq: 1'b0, seq_addr: ADDR_RESET, cont: 1'b0,
                wrap: WRAP_RESET, wrap_tgl: 1'b0, buf_valid: 1'b0, default: 1'b0};
    end else begin
      lk_q <= lk_d;
    end
  end

  always_ff @(posedge spi_sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fr_q <= '{state: LS_CMD, cnt: 5'd0, shreg: 8'h00, addr: ADDR_RESET, default: '0};
    end else begin
      fr_q <= fr_d;
    end
  end

  // bus side: one wait state, then answer
  always_comb begin
    bs_d = bs_q;
    bs_d.sleep_s1 = lk_q.sleep;
    bs_d.sleep_s2 = bs_q.sleep_s1;
    bs_d.ultra_s1 = lk_q.ultra;
    bs_d.ultra_s2 = bs_q.ultra_s1;
    bs_d.seq_s1 = lk_q.seq;
    bs_d.seq_s2 = bs_q.seq_s1;
    bs_d.cont_s1 = lk_q.cont;
    bs_d.cont_s2 = bs_q.cont_s1;
    bs_d.tgl_s1 = lk_q.wrap_tgl;
    bs_d.tgl_s2 = bs_q.tgl_s1;
    bs_d.tgl_s3 = bs_q.tgl_s2;
    bs_d.buf_s1 = lk_q.buf_valid;
    bs_d.buf_s2 = bs_q.buf_s1;
    // wrap word stands still long before its toggle is seen here
    if (bs_q.tgl_s2 != bs_q.tgl_s3) begin
      bs_d.wrap = lk_q.wrap;
    end
    bs_d.pready = psel & penable & ~bs_q.pready;
    bs_d.pslverr = 1'b0;
    if (psel & penable & ~bs_q.pready) begin
      bs_d.prdata = 32'h0000_0000;
      case (paddr)
        OFS_PPRC: begin
          bs_d.prdata[BIT_PDS] = bs_q.pds;
          bs_d.prdata[BIT_SEQ] = bs_q.seq_s2;
          bs_d.prdata[BIT_XIP] = bs_q.continuous_read_select;
          bs_d.prdata[2:0] = bs_q.wrap;
        end
        OFS_CFG: bs_d.prdata[BIT_QE] = bs_q.qe;
        OFS_STAT: bs_d.prdata[3:0] = {bs_q.buf_s2, bs_q.cont_s2, bs_q.ultra_s2, bs_q.sleep_s2};
        default: bs_d.pslverr = 1'b1;
      endcase
    end
    if (psel & penable & bs_q.pready & pwrite & pstrb[0]) begin
      if (paddr == OFS_PPRC) begin
        bs_d.pds = pwdata[BIT_PDS];
        bs_d.continuous_read_select = pwdata[BIT_XIP];
      end
      if (paddr == OFS_CFG) begin
        bs_d.qe = pwdata[BIT_QE];
      end
    end
    bs_d.hold_en = ~bs_d.qe;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bs_q <= '{pds: 1'b0, continuous_read_select: 1'b0, qe: 1'b0, prdata: 32'h0000_0000, wrap: WRAP_RESET,
                hold_en: 1'b1, default: 1'b0};
    end else begin
      bs_q <= bs_d;
    end
  end

  assign prdata = bs_q.prdata;
  assign pready = bs_q.pready;
  assign pslverr = bs_q.pslverr;
  assign io_out = fr_q.io_out;
  assign io_oe = fr_q.io_oe;
  assign sleep_active = lk_q.sleep;
  assign ultra_deep_active = lk_q.ultra;
  assign page_buf_valid = lk_q.buf_valid;
  assign hold_function_en = bs_q.hold_en;

  sequence s_cmd(logic [7:0] c);
    cmd_done && cmd_next == c;
  endsequence

  property p_pd_ultra;
    @(posedge spi_sck) disable iff (!presetn)
    (s_cmd(CMD_POWER_DOWN) and (!lk_q.sleep && !lk_q.pds_s2)) |=>
      lk_q.sleep && lk_q.ultra && !lk_q.buf_valid;
  endproperty
  a_pd_ultra: assert property (p_pd_ultra) else $error("ultra sleep not entered");

  property p_ultra_cmd;
    @(posedge spi_sck) disable iff (!presetn)
    (s_cmd(CMD_ULTRA_SLEEP) and !lk_q.sleep) |=> lk_q.sleep && lk_q.ultra && !lk_q.buf_valid;
  endproperty
  a_ultra_cmd: assert property (p_ultra_cmd) else $error("ultra instruction mismatch");

  property p_pd_deep;
    @(posedge spi_sck) disable iff (!presetn)
    (s_cmd(CMD_POWER_DOWN) and (!lk_q.sleep && lk_q.pds_s2)) |=>
      lk_q.sleep && !lk_q.ultra && $stable(lk_q.buf_valid);
  endproperty
  a_pd_deep: assert property (p_pd_deep) else $error("deep sleep wrong");

  property p_wake_only;
    @(posedge spi_sck) disable iff (!presetn)
    (lk_q.sleep && !(cmd_done && cmd_next == CMD_WAKE)) |=> lk_q.sleep;
  endproperty
  a_wake_only: assert property (p_wake_only) else $error("woke without wake");

  property p_sleep_ignore;
    @(posedge spi_sck) disable iff (!presetn)
    (lk_q.sleep && cmd_done && cmd_next != CMD_WAKE) |->
      (fr_d.state == LS_IGNORE) ##1 (lk_q.sleep && $stable(lk_q.seq));
  endproperty
  a_sleep_ignore: assert property (p_sleep_ignore) else $error("instruction taken asleep");

  property p_seq_set;
    @(posedge spi_sck) disable iff (!presetn)
    $rose(lk_q.seq) |-> $past(cmd_done && cmd_next == CMD_SEQ_PROG && !lk_q.sleep);
  endproperty
  a_seq_set: assert property (p_seq_set) else $error("sequential flag set unexpectedly");

  property p_seq_noaddr;
    @(posedge spi_sck) disable iff (!presetn)
    (s_cmd(CMD_SEQ_PROG) and (lk_q.seq && !lk_q.sleep)) |->
      fr_d.state == LS_DATA && fr_d.addr == lk_q.seq_addr;
  endproperty
  a_seq_noaddr: assert property (p_seq_noaddr) else $error("sequential address not reused");

  property p_cont_arm;
    @(posedge spi_sck) disable iff (!presetn)
    $rose(lk_q.cont) |-> $past(lk_q.xip_s2 && lk_q.qe_s2);
  endproperty
  a_cont_arm: assert property (p_cont_arm) else $error("continuous mode armed badly");

  property p_cont_gate;
    @(posedge spi_sck) disable iff (!presetn)
    !(lk_q.xip_s2 && lk_q.qe_s2) |=> !lk_q.cont;
  endproperty
  a_cont_gate: assert property (p_cont_gate) else $error("continuous without enables");

  property p_noinstr;
    @(posedge spi_sck) disable iff (!presetn)
    (fr_q.state == LS_CMD && fr_q.cnt == 5'd0 && cont_ok && !lk_q.sleep && !held) |=>
      fr_q.state == LS_ADDR && fr_q.quad && fr_q.cnt == 5'd1;
  endproperty
  a_noinstr: assert property (p_noinstr) else $error("address-only access refused");

  property p_wrap_mirror;
    @(posedge pclk) disable iff (!presetn)
    (bs_q.tgl_s2 != bs_q.tgl_s3) |=> bs_q.wrap == $past(lk_q.wrap);
  endproperty
  a_wrap_mirror: assert property (p_wrap_mirror) else $error("wrap field not mirrored");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && paddr == OFS_PPRC) |=> pready && prdata[5:4] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
endmodule

// ---- testbench/fsrf_host.sv ----
// spi host model for the config block link, mode 0, msb first
// assumes the bench resolves the io lines and feeds them back as io_wire
`timescale 1ns/1ps
module fsrf_host (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic [3:0] host_io,
  input wire logic [3:0] io_wire
);
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    host_io = 4'hA;
  end
  // released lines flip, io3 pulled up since it may be the hold pin
  task automatic clk(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] s);
    host_io = (v & oe) | (~host_io & ~oe & 4'h7) | (~oe & 4'h8);
    #40 spi_sck = 1'b1;
    #1 s = io_wire;
    #39 spi_sck = 1'b0;
  endtask
  // odd offset keeps the link out of phase with pclk
  task automatic begin_f();
    #13 spi_cs_n = 1'b0;
  endtask
  // sck stands still between frames
  task automatic end_f();
    #40 spi_cs_n = 1'b1;
    host_io = ~host_io | 4'h8;
    #80;
  endtask
  task automatic byte1(input logic [7:0] b);
    logic [3:0] s;
    for (int i = 7; i >= 0; i--) clk({3'h0, b[i]}, 4'h1, s);
  endtask
  task automatic toggle();
    begin_f();
    end_f();
  endtask
  task automatic send(input logic [7:0] q[$]);
    begin_f();
    foreach (q[i]) byte1(q[i]);
    end_f();
  endtask
  // frame left open so the bench can look at the pins before closing it
  task automatic quad(input logic c_en, input logic [7:0] c, input logic [23:0] a,
      output logic [7:0] d);
    logic [3:0] s;
    begin_f();
    if (c_en) byte1(c);
    for (int i = 5; i >= 0; i--) clk(a[i*4+:4], 4'hF, s);
    clk(4'h0, 4'h0, s);
    clk(4'h0, 4'h0, s);
    d[7:4] = s;
    clk(4'h0, 4'h0, s);
    d[3:0] = s;
  endtask
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the power/program/read config block
// assumes fsrf_host drives the link and an apb master here runs on pclk
`timescale 1ns/1ps
module tb
  import fsrf_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'hF, io_out, io_oe, host_io, io_w;
  logic pready, pslverr, spi_sck, spi_cs_n, sleep_active, ultra_deep_active;
  logic page_buf_valid, hold_function_en, e;
  logic m_pds = 1'b0, m_seq = 1'b0, m_xip = 1'b0, m_qe = 1'b0;
  logic m_slp = 1'b0, m_ult = 1'b0, m_pb = 1'b0, m_arm = 1'b0;
  logic [2:0] m_wrap = WRAP_RESET;
  logic [7:0] d;
  logic [23:0] a;
  integer seed = 32'hacd1_0dfa, error_cnt = 0, compares = 0, cyc = 0;
  always #10 pclk = ~pclk;
  // device wins where it drives, else whatever the host leaves
  assign io_w = (io_oe & io_out) | (~io_oe & host_io);
  fsrf_top u_fsrf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .io_in(io_w), .io_out(io_out), .io_oe(io_oe), .sleep_active(sleep_active),
    .ultra_deep_active(ultra_deep_active), .page_buf_valid(page_buf_valid),
    .hold_function_en(hold_function_en));
  fsrf_host u_fsrf_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .host_io(host_io),
    .io_wire(io_w));
  task automatic conclude();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // no fixed latency assumed, the wait runs until pready, bounded only by the timeout
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] ad, input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk(r, x);
  endtask
  // status lags the link by a few pclk through the synchroniser
  task automatic check_all();
    repeat (4) @(posedge pclk);
    rchk(OFS_PPRC, {24'h0, m_pds, m_seq, 2'h0, m_xip, m_wrap});
    rchk(OFS_CFG, {31'h0, m_qe});
    apb(1'b0, OFS_STAT, 32'h0);
    chk(r & 32'hF, {28'h0, m_pb, m_arm, m_ult, m_slp});
    chk({28'h0, hold_function_en, page_buf_valid, ultra_deep_active, sleep_active},
      {28'h0, ~m_qe, m_pb, m_ult, m_slp});
  endtask
  task automatic settle();
    u_fsrf_host.send('{8'h00});
  endtask
  task automatic qchk(input logic c_en, input logic [7:0] c);
    u_fsrf_host.quad(c_en, c, a, d);
    chk({24'h0, d}, {24'h0, a[3:0], a[3:0] + 4'h1});
    u_fsrf_host.end_f();
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    check_all();
    apb(1'b0, 12'hFF0, 32'h0);
    chk({r[30:0], e}, 32'h1);
    repeat (4) begin
      d = 8'($random(seed));
      apb(1'b1, OFS_PPRC, {24'h0, d | 8'h70});
      m_pds = d[7];
      m_xip = d[3];
      check_all();
    end
    pstrb <= 4'h0;
    apb(1'b1, OFS_PPRC, {24'h0, ~m_pds, 3'h0, ~m_xip, 3'h0});
    pstrb <= 4'hF;
    check_all();
    apb(1'b1, OFS_PPRC, 32'h0);
    {m_pds, m_xip} = 2'b00;
    settle();
    u_fsrf_host.send('{CMD_SEQ_PROG, 8'h01, 8'h23, 8'h45, 8'h5A});
    {m_seq, m_pb} = 2'b11;
    u_fsrf_host.send('{CMD_SEQ_PROG, 8'hA5});
    check_all();
    u_fsrf_host.send('{CMD_WRITE_DISABLE});
    m_seq = 1'b0;
    u_fsrf_host.send('{CMD_POWER_DOWN});
    {m_slp, m_ult, m_pb} = 3'b110;
    check_all();
    u_fsrf_host.toggle();
    u_fsrf_host.send('{CMD_SET_WRAP, 8'h70});
    u_fsrf_host.send('{CMD_SEQ_PROG, 8'h00, 8'h00, 8'h10, 8'hC3});
    check_all();
    u_fsrf_host.send('{CMD_WAKE});
    {m_slp, m_ult} = 2'b00;
    check_all();
    u_fsrf_host.send('{CMD_ULTRA_SLEEP});
    {m_slp, m_ult} = 2'b11;
    check_all();
    u_fsrf_host.send('{CMD_WAKE});
    {m_slp, m_ult} = 2'b00;
    u_fsrf_host.send('{CMD_SEQ_PROG, 8'h00, 8'h02, 8'h00, 8'h96});
    u_fsrf_host.send('{CMD_WRITE_DISABLE});
    apb(1'b1, OFS_PPRC, 32'h80);
    {m_pds, m_pb} = 2'b11;
    settle();
    u_fsrf_host.send('{CMD_POWER_DOWN});
    m_slp = 1'b1;
    check_all();
    u_fsrf_host.send('{CMD_WAKE});
    m_slp = 1'b0;
    d = 8'($random(seed));
    u_fsrf_host.send('{CMD_SET_WRAP, d});
    m_wrap = d[6:4];
    check_all();
    apb(1'b1, OFS_PPRC, 32'h88);
    m_xip = 1'b1;
    settle();
    a = 24'($random(seed));
    u_fsrf_host.quad(1'b1, CMD_QREAD_B, a, d);
    chk({28'h0, io_oe}, 32'h0);
    u_fsrf_host.end_f();
    apb(1'b1, OFS_PPRC, 32'h80);
    apb(1'b1, OFS_CFG, 32'h1);
    {m_xip, m_qe} = 2'b01;
    check_all();
    settle();
    qchk(1'b1, CMD_QREAD_A);
    apb(1'b1, OFS_PPRC, 32'h88);
    m_xip = 1'b1;
    settle();
    a = 24'($random(seed));
    qchk(1'b1, CMD_QREAD_B);
    m_arm = 1'b1;
    repeat (2) begin
      a = 24'($random(seed));
      qchk(1'b0, 8'h00);
    end
    check_all();
    conclude();
  end
endmodule
